// file: rtl/bmr_pkg.sv
package bmr_pkg;
  typedef enum logic [3:0] {
    BMR_MODE_NONE = 4'h1,
    BMR_MODE_EPROM = 4'h2,
    BMR_MODE_HOST = 4'h4,
    BMR_MODE_EXT = 4'h8
  } bmr_mode_t;

  typedef enum logic [2:0] {
    BMR_ST_RESET = 3'h1,
    BMR_ST_LAUNCH = 3'h2,
    BMR_ST_RUN = 3'h4
  } bmr_state_t;

  localparam int BMR_PC_W = 24;
  localparam logic [23:0] BMR_RESET_VECTOR = 24'h008005;
  localparam logic [23:0] BMR_EXT_VECTOR = 24'h020000;
  localparam int BMR_SYNC_STAGES = 3;
  localparam int BMR_SDRAM_CLK_PINS = 2;
  localparam int BMR_HOST_WIDTH_BIT = 0;
endpackage

// file: rtl/bmr_sync.sv
`timescale 1ns/1ps
module bmr_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pin in, filtered level out
  input wire logic pin_i,
  output logic level_o
);
  logic [2:0] sh_q;
  logic [2:0] sh_d;
  logic lvl_q;
  logic lvl_d;

  always_comb begin
    sh_d = {sh_q[1:0], pin_i};
    // first stage is only read by the second
    lvl_d = (sh_q[1] == sh_q[2]) ? sh_q[2] : lvl_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sh_q <= 3'h0;
      lvl_q <= 1'b0;
    end else begin
      sh_q <= sh_d;
      lvl_q <= lvl_d;
    end
  end

  assign level_o = lvl_q;
endmodule

// file: rtl/bmr_boot_cfg.sv
`timescale 1ns/1ps
module bmr_boot_cfg
  import bmr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // straps and bus state pins
  input wire logic boot_source_select,
  input wire logic boot_memory_select_i,
  input wire logic suspend_bus_three_state_n,
  input wire logic bus_master,
  // configuration
  input wire logic [7:0] system_config_register,
  // core side
  input wire logic eprom_cs_req,
  // boot memory select pin
  output logic boot_memory_select_o,
  output logic boot_memory_select_oe,
  // sdram clock pins
  output logic [BMR_SDRAM_CLK_PINS-1:0] sdram_clock_out,
  output logic [BMR_SDRAM_CLK_PINS-1:0] sdram_clock_oe,
  // status to the core
  output bmr_mode_t boot_mode,
  output logic host_bus_width,
  output logic core_run,
  output logic [BMR_PC_W-1:0] fetch_addr,
  output logic fetch_start
);

  // synchronised pin levels
  logic src_sel_s;
  logic mem_sel_s;
  logic suspend_n_s;

  // boot mode capture
  bmr_mode_t mode_q;
  bmr_mode_t mode_d;

  logic host_width_q;
  logic host_width_d;

  // start-up sequencer
  bmr_state_t st_q;
  bmr_state_t st_d;

  logic [BMR_PC_W-1:0] pc_q;
  logic [BMR_PC_W-1:0] pc_d;

  // status to the core
  logic run_q;
  logic run_d;

  logic start_q;
  logic start_d;

  // chip select and pin drive
  logic cs_q;
  logic cs_d;

  logic drive;

  // straps and the suspend input come from pins; none of them is reset
  bmr_sync bmr_sync_src_inst (
    .clk(clk),
    .rst(1'b0),
    .pin_i(boot_source_select),
    .level_o(src_sel_s)
  );

  bmr_sync bmr_sync_mem_inst (
    .clk(clk),
    .rst(1'b0),
    .pin_i(boot_memory_select_i),
    .level_o(mem_sel_s)
  );

  bmr_sync bmr_sync_susp_inst (
    .clk(clk),
    .rst(1'b0),
    .pin_i(suspend_bus_three_state_n),
    .level_o(suspend_n_s)
  );

  // unknown strap levels fall to no boot rather than a guess at a loader
  function automatic bmr_mode_t decode_mode(input logic src, input logic mem);
    case ({src, mem})
      2'h2, 2'h3: begin
        decode_mode = BMR_MODE_EPROM;
      end

      2'h1: begin
        decode_mode = BMR_MODE_HOST;
      end

      2'h0: begin
        decode_mode = BMR_MODE_EXT;
      end

      default: begin
        decode_mode = BMR_MODE_EXT;
      end
    endcase
  endfunction

  // chip select and the pin enable both ask this
  function automatic logic is_eprom(input bmr_mode_t mode);
    is_eprom = (mode == BMR_MODE_EPROM);
  endfunction

  // straps are taken on every clock edge while reset is held; the last one before release wins
  always_comb begin
    mode_d = mode_q;
    host_width_d = host_width_q;

    if (rst) begin
      mode_d = decode_mode(src_sel_s, mem_sel_s);
      host_width_d = system_config_register[BMR_HOST_WIDTH_BIT];
    end
  end

  always_ff @(posedge clk) begin
    mode_q <= mode_d;
    host_width_q <= host_width_d;
  end

  // reset parks the sequencer; release walks it through launch into run
  always_comb begin
    st_d = st_q;
    pc_d = pc_q;

    if (rst) begin
      st_d = BMR_ST_RESET;
      pc_d = BMR_RESET_VECTOR;
    end else begin
      case (st_q)
        BMR_ST_RESET: begin
          st_d = BMR_ST_LAUNCH;
          pc_d = BMR_RESET_VECTOR;
        end

        BMR_ST_LAUNCH: begin
          // no boot skips the loader and fetches straight from external memory
          pc_d = (mode_q == BMR_MODE_EXT) ? BMR_EXT_VECTOR : BMR_RESET_VECTOR;
          st_d = BMR_ST_RUN;
        end

        BMR_ST_RUN: begin
          st_d = BMR_ST_RUN;
        end

        default: begin
          // a lost state goes back to reset rather than running on
          st_d = BMR_ST_RESET;
          pc_d = BMR_RESET_VECTOR;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    st_q <= st_d;
    pc_q <= pc_d;
  end

  // status comes from flops that track the sequencer's next state
  always_comb begin
    run_d = (st_d == BMR_ST_RUN);
    start_d = (st_d == BMR_ST_LAUNCH);
  end

  always_ff @(posedge clk) begin
    run_q <= run_d;
    start_q <= start_d;
  end

  // chip select idles high outside eprom mode and while in reset
  always_comb begin
    cs_d = 1'b1;

    if (!rst && is_eprom(mode_q)) begin
      cs_d = ~eprom_cs_req;
    end
  end

  always_ff @(posedge clk) begin
    cs_q <= cs_d;
  end

  // bus slave or suspend floats every three-statable output
  assign drive = bus_master & suspend_n_s;

  // clk already is the doubled rate; each pin toggles once per cycle
  // a flop per pin, so every clock pin has a driver of its own
  for (genvar i = 0; i < BMR_SDRAM_CLK_PINS; i++) begin : g_sdram_clk
    logic tog_q;
    logic tog_d;

    always_comb begin
      tog_d = rst ? 1'b0 : ~tog_q;
    end

    always_ff @(posedge clk) begin
      tog_q <= tog_d;
    end

    assign sdram_clock_out[i] = tog_q;
    assign sdram_clock_oe[i] = drive;
  end

  // the pin carries the registered select, high while idle
  assign boot_memory_select_o = cs_q;
  // in the other modes the line is an input and never driven
  assign boot_memory_select_oe = is_eprom(mode_q) && drive && !rst;

  assign boot_mode = mode_q;
  assign host_bus_width = host_width_q;

  assign core_run = run_q;
  assign fetch_addr = pc_q;
  assign fetch_start = start_q;

endmodule

// file: dv/bmr_boot_cfg_props.sv
`timescale 1ns/1ps
module bmr_boot_cfg_chk
  import bmr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic suspend_bus_three_state_n,
  input wire logic bus_master,
  input wire logic eprom_cs_req,
  input wire logic boot_memory_select_o,
  input wire logic boot_memory_select_oe,
  input wire logic [BMR_SDRAM_CLK_PINS-1:0] sdram_clock_out,
  input wire logic [BMR_SDRAM_CLK_PINS-1:0] sdram_clock_oe,
  input wire bmr_mode_t boot_mode,
  input wire logic core_run,
  input wire logic [BMR_PC_W-1:0] fetch_addr,
  input wire logic fetch_start
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_clk_toggle: assert property (!$past(rst) |-> sdram_clock_out == ~$past(sdram_clock_out))
    else $error("sdram clock did not toggle");
  chk_start_pulse: assert property ($rose(fetch_start) |=> !fetch_start && core_run)
    else $error("start pulse or run wrong");
  chk_start_addr: assert property (fetch_start |=> fetch_addr ==
    (boot_mode == BMR_MODE_EXT ? BMR_EXT_VECTOR : BMR_RESET_VECTOR)) else $error("start address wrong");
  chk_run_held: assert property (core_run |=> core_run)
    else $error("run dropped outside reset");
  chk_mode_held: assert property (!$past(rst) |-> $stable(boot_mode))
    else $error("boot mode changed after reset");
  chk_oe_eprom: assert property (boot_memory_select_oe |-> boot_mode == BMR_MODE_EPROM)
    else $error("select pin driven outside eprom mode");
  chk_slave_float: assert property (!bus_master ##1 !bus_master |-> !boot_memory_select_oe)
    else $error("slave drives select pin");
  chk_suspend_float: assert property (!suspend_bus_three_state_n [*5] |->
    !boot_memory_select_oe && sdram_clock_oe == '0) else $error("outputs not floated");
  chk_cs_follow: assert property (boot_memory_select_oe && $past(boot_memory_select_oe) |->
    boot_memory_select_o == !$past(eprom_cs_req)) else $error("chip select wrong");
endmodule
bind bmr_boot_cfg bmr_boot_cfg_chk bmr_boot_cfg_chk_inst (.*);

// file: dv/bmr_board.sv
`timescale 1ns/1ps
module bmr_board (
  // straps and pin drive
  input wire logic strap_src,
  input wire logic strap_mem,
  input wire logic pin_o,
  input wire logic pin_oe,
  // levels at the device
  output logic src_pin,
  output logic mem_pin,
  // test logic reset
  output logic test_reset_n
);
  // held low for good: the block has no scan logic to release
  assign test_reset_n = 1'b0;
  assign src_pin = strap_src;
  // strap resistor only wins while the device lets go
  assign mem_pin = pin_oe ? pin_o : strap_mem;
endmodule

// file: dv/boot_mode_reset_config_bench.sv
`timescale 1ns/1ps
module boot_mode_reset_config_bench;
  import bmr_pkg::*;
  logic clk = 0, rst = 1, s = 0, m = 0, sb_n = 1, mst = 1, req = 0, sp, mp, o, oe, host_w, run, fs, trst_n;
  logic [7:0] cfg = 8'h00;
  logic [1:0] sc, soe, c;
  bmr_mode_t md;
  logic [23:0] fa;
  int failures = 0, checked = 0;
  always #5 clk = ~clk;
  bmr_board bmr_board_inst (.strap_src(s), .strap_mem(m), .pin_o(o), .pin_oe(oe), .src_pin(sp), .mem_pin(mp),
    .test_reset_n(trst_n));
  bmr_boot_cfg bmr_boot_cfg_inst (.clk(clk), .rst(rst), .boot_source_select(sp), .boot_memory_select_i(mp),
    .suspend_bus_three_state_n(sb_n), .bus_master(mst), .system_config_register(cfg), .eprom_cs_req(req),
    .boot_memory_select_o(o), .boot_memory_select_oe(oe), .sdram_clock_out(sc), .sdram_clock_oe(soe),
    .boot_mode(md), .host_bus_width(host_w), .core_run(run), .fetch_addr(fa), .fetch_start(fs));
  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      failures++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic report_and_stop();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  function automatic bmr_mode_t exp_mode(input logic bs, input logic bm);
    return bs ? BMR_MODE_EPROM : (bm ? BMR_MODE_HOST : BMR_MODE_EXT);
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // the source strap only moves while reset is held, as a hardwired board would see at power-up
  task automatic boot(input logic bs, input logic bm);
    int n;
    rst = 1;
    s = bs;
    m = bm;
    cfg = 8'($urandom);
    tick(10);
    rst = 0;
    n = 0;
    while (fs !== 1'b1 && n < 4) begin
      tick(1);
      n++;
    end
    if (n == 4) begin
      failures++;
      report_and_stop();
    end
    chk(md === exp_mode(bs, bm), "boot mode");
    chk(host_w === cfg[BMR_HOST_WIDTH_BIT], "host width");
    chk(bs || oe === 1'b0, "select pin driven");
    tick(1);
    chk(run === 1'b1 && fs === 1'b0, "run");
    chk(fa === ((bs | bm) ? BMR_RESET_VECTOR : BMR_EXT_VECTOR), "start address");
    chk(bs || o === 1'b1, "select not idle");
    chk(trst_n === 1'b0, "test reset released");
    // a memory strap that moves after release must not reach the mode
    m = ~bm;
    tick(6);
    chk(md === exp_mode(bs, bm), "strap change taken");
  endtask
  initial begin
    void'($urandom(15));
    tick(10);
    for (int i = 0; i < 6; i++) boot(i % 3 == 2, i % 3 == 1);
    m = 1'b1;
    tick(4);
    repeat (8) begin
      req = 1'($urandom);
      c = sc;
      tick(1);
      chk(oe === 1'b1 && o === ~req, "chip select");
      chk(sc === ~c && soe === 2'h3, "sdram clock");
    end
    chk(md === BMR_MODE_EPROM, "mode held");
    sb_n = 0;
    tick(6);
    chk(oe === 1'b0 && soe === 2'h0, "suspend float");
    sb_n = 1;
    mst = 0;
    tick(6);
    chk(oe === 1'b0 && soe === 2'h0, "slave float");
    report_and_stop();
  end
endmodule
